//--- logic/smic_regs.vh
// Purpose: Shared constants of the sensor mode and interrupt control bank.
// Assumes: Included by the top-level design file by bare name.
// Notes:   Register addresses are the 4-bit serial-port register numbers.
`ifndef SMIC_REGS_VH
`define SMIC_REGS_VH

// Register addresses.
`define SMIC_ADDR_EVENT_STATUS   4'h0
`define SMIC_ADDR_OPERATING_MODE 4'h1
`define SMIC_ADDR_IRQ_ENABLE     4'h2
`define SMIC_ADDR_HEATER_CONFIG  4'h3
`define SMIC_ADDR_POINTER_CONFIG 4'h4
`define SMIC_ADDR_TAP_CONFIG     4'h5
`define SMIC_ADDR_MOTION_THRESH  4'h6
`define SMIC_ADDR_POINTER_REPORT 4'h8

// Command byte layout: read flag and address field.
`define SMIC_CMD_READ_BIT        7
`define SMIC_CMD_ADDR_MSB        3

// Status bit positions.
`define SMIC_ST_TAP              7
`define SMIC_ST_MOTION           6
`define SMIC_ST_TEST_EDGE        5
`define SMIC_ST_TEST_ROW         4
`define SMIC_ST_FAULT            3

// Operating mode register fields.
`define SMIC_MODE_MSB            6
`define SMIC_MODE_LSB            3
`define SMIC_MODE_PD_BIT         2
`define SMIC_MODE_TEST           0
`define SMIC_MODE_TAP            1
`define SMIC_MODE_NAV            2
`define SMIC_MODE_ACQ            3

// Interrupt enable field: bits 6 to 2 gate status bits 7 to 3.
`define SMIC_EN_MSB              6
`define SMIC_EN_LSB              2

// Heater watchdog enable bit.
`define SMIC_HEAT_WDOG_BIT       5

// Reset values.
`define SMIC_RST_MODE            4'h0
`define SMIC_RST_PD              1'b1
`define SMIC_RST_IRQ_EN          5'h00
`define SMIC_RST_HEATER          7'h00
`define SMIC_RST_POINTER_CFG     7'h40
`define SMIC_RST_TAP_CFG         7'h1d
`define SMIC_RST_MOTION_THRESH   7'h00

// Number of extra report bytes after the first pointer report byte.
`define SMIC_REPORT_EXTRA        2'h2

`endif

//--- logic/smic_slice_tx.v
// Purpose: Shift image slice bytes out on the high-speed serial port.
// Assumes: Port clock edges arrive already synchronised and edge-detected.
// Notes:   MSB first, data changes after each falling port clock edge.
`timescale 1ns/1ps
`default_nettype none

module smic_slice_tx (
  // Clock and reset.
  input  wire       i_clock,
  input  wire       i_rstn,
  // Control from the mode logic.
  input  wire       i_enable,
  input  wire       i_frame,
  input  wire       i_sck_fall,
  // Slice byte source.
  input  wire [7:0] i_slice_byte,
  input  wire       i_slice_valid,
  output wire       o_slice_ready,
  // Serial output.
  output reg        o_data,
  output wire       o_data_oe
);

  reg [7:0] shift_q;   // Bits still to send.
  reg [3:0] left_q;    // Bits left in the current byte.

  // Take a new byte only when the previous one is fully sent.
  assign o_slice_ready = i_enable & i_frame & (left_q == 4'h0);
  assign o_data_oe     = i_enable & i_frame;

  // Shifter; an abandoned frame drops the partial byte on purpose.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      shift_q <= 8'h00;
      left_q  <= 4'h0;
      o_data  <= 1'b0;
    end else if (!(i_enable & i_frame)) begin
      left_q  <= 4'h0;
    end else if (o_slice_ready && i_slice_valid) begin
      shift_q <= i_slice_byte;
      left_q  <= 4'h8;
    end else if (i_sck_fall && (left_q != 4'h0)) begin
      o_data  <= shift_q[7];
      shift_q <= {shift_q[6:0], 1'b0};
      left_q  <= left_q - 4'h1;
    end
  end

endmodule

`default_nettype wire

//--- logic/smic_sync.v
// Purpose: Two-flop synchroniser for a group of asynchronous inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
`default_nettype none

module smic_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset.
  input  wire             i_clock,
  input  wire             i_rstn,
  // Asynchronous levels in, synchronised levels out.
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;   // First stage, may go metastable.
  reg [WIDTH-1:0] sync_q;   // Second stage, safe to use.

  // Both stages reset to zero; the owner must treat that as a valid level.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

//--- logic/smic_top.v
// Purpose: Mode control and event interrupt register bank of a swipe sensor.
// Assumes: i_clock at 40 MHz, far faster than either serial port clock.
// Notes:   Serial pins are synchronised; event inputs come from local logic.
`timescale 1ns/1ps
`default_nettype none
`include "smic_regs.vh"

// Contract
// RL1: Reset pin stops clocks, initialises every register.
// RL2: Control on slow port, slices on fast.
// RL3: Standby keeps only port and control alive.
// RL4: Tap mode enables oscillator, tap array, detector.
// RL5: Navigation mode enables oscillator, array, motion block.
// RL6: Acquisition enables fast port; oscillator for watchdog.
// RL7: Four-bit address selects each register.
// RL8: Pointer report read returns three bytes.
// RL9: Status bits: tap, motion, fault, test.
// RL10: Reading status clears every flag.
// RL11: Mode field bits 6..3 select mode.
// RL12: Mode code 0110 runs tap and navigation.
// RL13: Acquisition combined with others is dropped; the code drops it only with tap or navigation, and keeps it with test.
// RL14: Bit 2 powers oscillator down, resets high.
// RL15: Tap, navigation idle while oscillator is down.
// RL16: Host leaves modes with two writes.
// RL17: Read-only registers unreadable while oscillator off.
// RL18: Host passes standby between navigation, acquisition.
// RL19: Enable bits gate status onto the interrupt.
// RL20: Interrupt drops once status has been read.
// RL21: Motion flag when movement exceeds threshold.
// RL22: Slave select frames transfers, releases output.
// RL23: Reserved addresses ignore writes, read zero.
module smic_top (
  // Clock and reset pin.
  input  wire       i_clock,
  input  wire       i_rstn,
  // Low-speed serial port pins.
  input  wire       i_sck,
  input  wire       i_ss_n,
  input  wire       i_mosi,
  output wire       o_miso,
  output wire       o_miso_oe,
  // High-speed serial port pins.
  input  wire       i_fast_sck,
  input  wire       i_fast_ss_n,
  output wire       o_fast_miso,
  output wire       o_fast_miso_oe,
  // Slice bytes from the acquisition path.
  input  wire [7:0] i_slice_byte,
  input  wire       i_slice_valid,
  output wire       o_slice_ready,
  // Events from the sensing blocks.
  input  wire       i_tap_event,
  input  wire       i_nav_update,
  input  wire [7:0] i_nav_general,
  input  wire [7:0] i_nav_x,
  input  wire [7:0] i_nav_y,
  input  wire       i_readout_fault,
  input  wire       i_test_edge,
  input  wire       i_test_row,
  // Block enables and configuration outputs.
  output wire       o_osc_enable,
  output wire       o_tap_enable,
  output wire       o_nav_enable,
  output wire       o_acq_enable,
  output wire       o_test_enable,
  output wire       o_nav_report_read,
  output wire [6:0] o_heater_config,
  output wire [6:0] o_pointer_config,
  output wire [6:0] o_tap_config,
  // Interrupt request, active high.
  output wire       o_irq
);

  // Serial engine states, one-hot.
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CMD  = 4'b0010;
  localparam [3:0] ST_WR   = 4'b0100;
  localparam [3:0] ST_RD   = 4'b1000;

  wire [4:0] pins_s;        // Synchronised pin levels.
  wire       sck_s;         // Slow port clock.
  wire       ss_n_s;        // Slow port select, active low.
  wire       mosi_s;        // Slow port data in.
  wire       fsck_s;        // Fast port clock.
  wire       fss_n_s;       // Fast port select, active low.

  reg        sck_prev_q;    // Last slow clock level, for edges.
  reg        fsck_prev_q;   // Last fast clock level, for edges.
  reg  [3:0] state_q;       // Serial engine state.
  reg  [3:0] state_d;
  reg  [2:0] bit_cnt_q;     // Bit position within a byte.
  reg  [7:0] shift_in_q;    // Incoming bits.
  reg  [7:0] shift_out_q;   // Outgoing bits.
  reg  [3:0] addr_q;        // Address of the current command.
  reg  [1:0] rd_left_q;     // Report bytes still to send.
  reg        miso_q;        // Slow port output bit.
  reg  [7:0] nav_x_hold_q;  // Report X captured at the command.
  reg  [7:0] nav_y_hold_q;  // Report Y captured at the command.

  reg  [3:0] mode_q;        // Mode field.
  reg        osc_pd_q;      // Oscillator power-down bit.
  reg  [4:0] irq_en_q;      // Interrupt enables, bits 6 to 2.
  reg  [6:0] heater_q;      // Heater configuration.
  reg  [6:0] pointer_q;     // Pointer tracking configuration.
  reg  [6:0] tap_cfg_q;     // Tap detection configuration.
  reg  [6:0] thresh_q;      // Motion threshold.
  reg  [7:0] status_q;      // Sticky event flags.
  reg  [7:0] status_d;
  reg  [7:0] rd_value;      // First byte answered to a read.
  reg  [3:0] mode_wr;       // Mode field after conflict filtering.

  wire       sck_rise;
  wire       sck_fall;
  wire       fsck_fall;
  wire       frame;
  wire       byte_done;
  wire [7:0] byte_in;
  wire       cmd_done;
  wire       cmd_is_read;
  wire [3:0] cmd_addr;
  wire       wr_strobe;
  wire       status_clr;
  wire       motion_hit;
  wire [7:0] set_mask;

  // Every pin from the host passes two flops before any logic sees it.
  smic_sync #(
    .WIDTH (5)
  ) u_pin_sync (
    .i_clock (i_clock),
    .i_rstn  (i_rstn),
    .i_async ({i_sck, i_ss_n, i_mosi, i_fast_sck, i_fast_ss_n}),
    .o_sync  (pins_s)
  );

  assign sck_s   = pins_s[4];
  assign ss_n_s  = pins_s[3];
  assign mosi_s  = pins_s[2];
  assign fsck_s  = pins_s[1];
  assign fss_n_s = pins_s[0];

  // Edge detection; the zero reset level of select reads as selected until the synchroniser passes the pin.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      sck_prev_q  <= 1'b0;
      fsck_prev_q <= 1'b0;
    end else begin
      sck_prev_q  <= sck_s;
      fsck_prev_q <= fsck_s;
    end
  end

  assign sck_rise  = sck_s & ~sck_prev_q;
  assign sck_fall  = ~sck_s & sck_prev_q;
  assign fsck_fall = ~fsck_s & fsck_prev_q;
  assign frame     = ~ss_n_s & i_rstn;                      // [RL22]

  // Byte assembly from the slow port, MSB first.
  assign byte_done   = frame & sck_rise & (bit_cnt_q == 3'h7);
  assign byte_in     = {shift_in_q[6:0], mosi_s};
  assign cmd_done    = byte_done & (state_q == ST_CMD);
  assign cmd_is_read = byte_in[`SMIC_CMD_READ_BIT];
  assign cmd_addr    = byte_in[`SMIC_CMD_ADDR_MSB:0];        // [RL7]
  assign wr_strobe   = byte_done & (state_q == ST_WR);

  // Status is cleared by its read only when it was really readable.
  assign status_clr = cmd_done & cmd_is_read & ~osc_pd_q &
                      (cmd_addr == `SMIC_ADDR_EVENT_STATUS);   // [RL10] [RL17]
  assign o_nav_report_read = cmd_done & cmd_is_read & ~osc_pd_q &
                             (cmd_addr == `SMIC_ADDR_POINTER_REPORT);

  // Next state of the serial engine.
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (frame) begin
          state_d = ST_CMD;
        end
      end
      ST_CMD: begin
        if (cmd_done) begin
          state_d = cmd_is_read ? ST_RD : ST_WR;
        end
      end
      ST_WR: begin
        // After one data byte a new command may follow in the same frame.
        if (byte_done) begin
          state_d = ST_CMD;
        end
      end
      ST_RD: begin
        if (byte_done && (rd_left_q == 2'h0)) begin
          state_d = ST_CMD;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (!frame) begin
      state_d = ST_IDLE;                                     // [RL22]
    end
  end

  // Read multiplexer for the first answered byte.
  always @* begin
    rd_value = 8'h00;                                        // [RL23]
    case (cmd_addr)
      `SMIC_ADDR_EVENT_STATUS: begin
        rd_value = osc_pd_q ? 8'h00 : status_q;              // [RL9] [RL17]
      end
      `SMIC_ADDR_OPERATING_MODE: begin
        rd_value = {1'b0, mode_q, osc_pd_q, 2'b00};
      end
      `SMIC_ADDR_IRQ_ENABLE: begin
        rd_value = {1'b0, irq_en_q, 2'b00};
      end
      `SMIC_ADDR_HEATER_CONFIG: begin
        rd_value = {1'b0, heater_q};
      end
      `SMIC_ADDR_POINTER_CONFIG: begin
        rd_value = {1'b0, pointer_q};
      end
      `SMIC_ADDR_TAP_CONFIG: begin
        rd_value = {1'b0, tap_cfg_q};
      end
      `SMIC_ADDR_MOTION_THRESH: begin
        rd_value = {1'b0, thresh_q};
      end
      `SMIC_ADDR_POINTER_REPORT: begin
        rd_value = osc_pd_q ? 8'h00 : i_nav_general;         // [RL8] [RL17]
      end
      default: begin
        rd_value = 8'h00;                                    // [RL23]
      end
    endcase
  end

  // Serial engine datapath: shift in on rising, shift out on falling edges.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q      <= ST_IDLE;
      bit_cnt_q    <= 3'h0;
      shift_in_q   <= 8'h00;
      shift_out_q  <= 8'h00;
      addr_q       <= 4'h0;
      rd_left_q    <= 2'h0;
      miso_q       <= 1'b0;
      nav_x_hold_q <= 8'h00;
      nav_y_hold_q <= 8'h00;
    end else begin
      state_q <= state_d;
      if (!frame) begin
        bit_cnt_q <= 3'h0;
        rd_left_q <= 2'h0;
      end else begin
        if (sck_rise) begin
          shift_in_q <= byte_in;
          bit_cnt_q  <= bit_cnt_q + 3'h1;
        end
        if (cmd_done) begin
          addr_q      <= cmd_addr;
          shift_out_q <= cmd_is_read ? rd_value : 8'h00;
          // The report is one read of three bytes, captured together.
          if (cmd_is_read && (cmd_addr == `SMIC_ADDR_POINTER_REPORT)) begin
            rd_left_q    <= osc_pd_q ? 2'h0 : `SMIC_REPORT_EXTRA;  // [RL8]
            nav_x_hold_q <= i_nav_x;
            nav_y_hold_q <= i_nav_y;
          end else begin
            rd_left_q <= 2'h0;
          end
        end else if (byte_done && (state_q == ST_RD) && (rd_left_q != 2'h0)) begin
          shift_out_q <= (rd_left_q == `SMIC_REPORT_EXTRA) ? nav_x_hold_q : nav_y_hold_q;
          rd_left_q   <= rd_left_q - 2'h1;                   // [RL8]
        end else if (sck_fall && (state_q == ST_RD)) begin
          miso_q      <= shift_out_q[7];
          shift_out_q <= {shift_out_q[6:0], 1'b0};
        end
      end
    end
  end

  // The data pin is driven only inside a frame.
  assign o_miso    = miso_q;
  assign o_miso_oe = frame;                                  // [RL22]

  // Acquisition never survives together with tap or navigation.
  always @* begin
    mode_wr = byte_in[`SMIC_MODE_MSB:`SMIC_MODE_LSB];        // [RL11]
    if (mode_wr[`SMIC_MODE_ACQ] && (mode_wr[`SMIC_MODE_NAV] || mode_wr[`SMIC_MODE_TAP])) begin
      mode_wr[`SMIC_MODE_ACQ] = 1'b0;                        // [RL13]
    end
  end

  // Writable registers; reserved addresses fall through untouched.
  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      mode_q    <= `SMIC_RST_MODE;                           // [RL1]
      osc_pd_q  <= `SMIC_RST_PD;                             // [RL14]
      irq_en_q  <= `SMIC_RST_IRQ_EN;                         // [RL19]
      heater_q  <= `SMIC_RST_HEATER;
      pointer_q <= `SMIC_RST_POINTER_CFG;
      tap_cfg_q <= `SMIC_RST_TAP_CFG;
      thresh_q  <= `SMIC_RST_MOTION_THRESH;
    end else if (wr_strobe) begin
      case (addr_q)
        `SMIC_ADDR_OPERATING_MODE: begin
          mode_q   <= mode_wr;                               // [RL12]
          osc_pd_q <= byte_in[`SMIC_MODE_PD_BIT];            // [RL14]
        end
        `SMIC_ADDR_IRQ_ENABLE: begin
          irq_en_q <= byte_in[`SMIC_EN_MSB:`SMIC_EN_LSB];
        end
        `SMIC_ADDR_HEATER_CONFIG: begin
          heater_q <= byte_in[6:0];
        end
        `SMIC_ADDR_POINTER_CONFIG: begin
          pointer_q <= byte_in[6:0];
        end
        `SMIC_ADDR_TAP_CONFIG: begin
          tap_cfg_q <= byte_in[6:0];
        end
        `SMIC_ADDR_MOTION_THRESH: begin
          thresh_q <= byte_in[6:0];
        end
        default: begin
          thresh_q <= thresh_q;                              // [RL23]
        end
      endcase
    end
  end

  // Block enables; tap and navigation need the oscillator running.
  assign o_tap_enable  = mode_q[`SMIC_MODE_TAP] & ~osc_pd_q;  // [RL4] [RL15]
  assign o_nav_enable  = mode_q[`SMIC_MODE_NAV] & ~osc_pd_q;  // [RL5] [RL15]
  assign o_acq_enable  = mode_q[`SMIC_MODE_ACQ];              // [RL6]
  assign o_test_enable = mode_q[`SMIC_MODE_TEST];
  // In acquisition the oscillator only serves the heater watchdog.
  assign o_osc_enable  = ~osc_pd_q &
                         (~mode_q[`SMIC_MODE_ACQ] | heater_q[`SMIC_HEAT_WDOG_BIT]); // [RL3] [RL6]
  assign o_heater_config  = heater_q;
  assign o_pointer_config = pointer_q;
  assign o_tap_config     = tap_cfg_q;

  // Movement beyond the threshold raises the motion flag.
  assign motion_hit = o_nav_enable & i_nav_update &
                      ((i_nav_x > {1'b0, thresh_q}) | (i_nav_y > {1'b0, thresh_q})); // [RL21]

  // Events other than the readout fault gated by the blocks that produce them.
  assign set_mask = {o_tap_enable & i_tap_event,
                     motion_hit,
                     o_test_enable & i_test_edge,
                     o_test_enable & i_test_row,
                     i_readout_fault,
                     3'b000};                                // [RL9]

  // Sticky flags; an event in the clearing cycle is kept.
  always @* begin
    status_d = status_q;
    if (status_clr) begin
      status_d = 8'h00;                                      // [RL10]
    end
    status_d = status_d | set_mask;
  end

  always @(posedge i_clock or negedge i_rstn) begin
    if (!i_rstn) begin
      status_q <= 8'h00;                                     // [RL1]
    end else begin
      status_q <= status_d;
    end
  end

  // Enable bits 6..2 line up with status bits 7..3.
  assign o_irq = |(status_q[`SMIC_ST_TAP:`SMIC_ST_FAULT] & irq_en_q); // [RL19] [RL20]

  // Slices leave on the fast port only in acquisition.
  smic_slice_tx u_slice_tx (
    .i_clock       (i_clock),
    .i_rstn        (i_rstn),
    .i_enable      (o_acq_enable),
    .i_frame       (~fss_n_s),
    .i_sck_fall    (fsck_fall),
    .i_slice_byte  (i_slice_byte),
    .i_slice_valid (i_slice_valid),
    .o_slice_ready (o_slice_ready),
    .o_data        (o_fast_miso),
    .o_data_oe     (o_fast_miso_oe)
  );                                                         // [RL2]

endmodule

`default_nettype wire

//--- test/smic_host.sv
// Purpose: Host model driving the slow serial port as master.
// Assumes: Mode 0, most significant bit first, 200 ns port clock.
// Notes:   The port clock stands still between frames.
`timescale 1ns/1ps
`default_nettype none
module smic_host (
  // Pins towards the device.
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi,
  // Data back from the device.
  input  wire logic i_miso,
  input  wire logic i_miso_oe
);
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b0;
  end
  // One frame: a command byte, then n data bytes; read bytes land in r.
  task frame(input logic [7:0] c, input logic [7:0] w, input int n, output logic [23:0] r);
    logic [7:0] b;
    r = 24'h000000;
    o_ss_n = 1'b0;
    #100;
    for (int k = 0; k <= n; k++) begin
      b = (k == 0) ? c : w;
      for (int i = 7; i >= 0; i--) begin
        o_mosi = b[i];
        #100 o_sck = 1'b1;
        // A released line shows the inverse of the last bit, never a lucky match.
        #50 if (k > 0) r = {r[22:0], i_miso_oe ? i_miso : ~r[0]};
        #50 o_sck = 1'b0;
      end
    end
    #100 o_ss_n = 1'b1;
    o_mosi = ~o_mosi;
    #200;
  endtask
endmodule
`default_nettype wire

//--- test/smic_top_chk.sv
// Purpose: Port assertions for the mode and interrupt bank.
// Assumes: Bound to every instance of smic_top.
// Notes:   Internal registers are not visible, so relations are between ports.
`timescale 1ns/1ps
`default_nettype none
module smic_top_chk (
  // Clock and reset.
  input wire logic i_clock, i_rstn,
  // Watched inputs and outputs.
  input wire logic i_ss_n, i_tap_event, i_nav_update, i_readout_fault, i_test_edge,
  input wire logic i_test_row, o_miso_oe, o_fast_miso_oe, o_osc_enable, o_tap_enable,
  input wire logic o_nav_enable, o_acq_enable, o_nav_report_read, o_irq,
  input wire logic [6:0] o_heater_config
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rstn);
  // Any event pulse; an interrupt may rise only on one or on a register write.
  wire ev = i_tap_event | i_nav_update | i_readout_fault | i_test_edge | i_test_row;
  // Registers are unknown until the first edge applies reset, so sleep is checked after it.
  logic seen_q = 1'b0;
  always @(posedge i_clock) seen_q <= 1'b1;
  AST_SLEEP:
  assert property (disable iff (1'b0) !i_rstn && seen_q |-> !o_osc_enable && !o_irq && !o_miso_oe)
    else $error("outputs active in sleep");
  AST_POINT_OSC:
  assert property (o_tap_enable || o_nav_enable |-> o_osc_enable) else $error("osc off");
  AST_ACQ_ALONE:
  assert property (o_acq_enable |-> !o_tap_enable && !o_nav_enable) else $error("acq mixed");
  AST_ACQ_OSC:
  assert property (o_acq_enable && !o_heater_config[5] |-> !o_osc_enable) else $error("acq osc");
  AST_OE_IDLE:
  assert property (i_ss_n [*4] |-> !o_miso_oe) else $error("data out driven while idle");
  AST_FAST_OE:
  assert property (o_fast_miso_oe |-> o_acq_enable) else $error("fast port outside acq");
  AST_IRQ_RISE:
  assert property ($rose(o_irq) |-> $past(ev) || $past(o_miso_oe)) else $error("irq rose");
  AST_IRQ_FALL:
  assert property ($fell(o_irq) |-> $past(o_miso_oe)) else $error("irq fell outside frame");
  AST_NAV_READ:
  assert property (o_nav_report_read |-> o_miso_oe ##1 !o_nav_report_read)
    else $error("report read pulse");
endmodule
bind smic_top smic_top_chk smic_top_chk_i (.*);
`default_nettype wire

//--- test/smic_top_tb.sv
// Purpose: Self-checking bench for the sensor mode and interrupt bank.
// Assumes: smic_host plays the host on the slow serial port.
// Notes:   Fast port and sensing events are driven here at falling edges.
`timescale 1ns/1ps
`default_nettype none
module smic_top_tb;
  logic i_clock = 1'b0, i_rstn = 1'b0, i_fast_sck = 1'b0, i_fast_ss_n = 1'b1;
  logic i_slice_valid = 1'b0, i_tap_event = 1'b0, i_nav_update = 1'b0;
  logic i_readout_fault = 1'b0, i_test_edge = 1'b0, i_test_row = 1'b0;
  logic [7:0] i_slice_byte = 8'h00, i_nav_general = 8'h00, i_nav_x = 8'h00, i_nav_y = 8'h00;
  wire i_sck, i_ss_n, i_mosi, o_miso, o_miso_oe, o_fast_miso, o_fast_miso_oe;
  wire o_slice_ready, o_osc_enable, o_tap_enable, o_nav_enable, o_acq_enable;
  wire o_test_enable, o_nav_report_read, o_irq;
  wire [6:0] o_heater_config, o_pointer_config, o_tap_config;
  int fails = 0, samples_checked = 0, cyc = 0;
  logic [23:0] r;
  logic [7:0] m, t, g, x, y;
  logic [7:0] cfg [3:6];
  logic [3:0] codes [9] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h6, 4'hc, 4'ha, 4'he};
  always #12.5 i_clock = ~i_clock;
  smic_top smic_top_i (.*);
  smic_host smic_host_i (.o_sck(i_sck), .o_ss_n(i_ss_n), .o_mosi(i_mosi),
                         .i_miso(o_miso), .i_miso_oe(o_miso_oe));
  task chk(input logic [7:0] gt, input logic [7:0] e);
    samples_checked++;
    if (gt !== e) begin
      fails++;
      $display("[FAIL] %0t got %h want %h", $time, gt, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    smic_host_i.frame({4'h0, a}, d, 1, r);
  endtask
  task rd(input logic [3:0] a, input int n);
    smic_host_i.frame({4'h8, a}, 8'h00, n, r);
  endtask
  // One-cycle event pulses with fresh motion counts beside them.
  task ev(input logic [4:0] v, input logic [7:0] xv, input logic [7:0] yv);
    @(negedge i_clock);
    {i_tap_event, i_nav_update, i_readout_fault, i_test_edge, i_test_row} = v;
    {i_nav_x, i_nav_y} = {xv, yv};
    @(negedge i_clock);
    {i_tap_event, i_nav_update, i_readout_fault, i_test_edge, i_test_row} = 5'h00;
    repeat (2) @(negedge i_clock);
  endtask
  // Acquisition is dropped when combined with tap or navigation.
  function logic [3:0] fix(input logic [3:0] c);
    return (c[3] && (c[2] || c[1])) ? {1'b0, c[2:0]} : c;
  endfunction
  function logic mot(input logic [7:0] xv, input logic [7:0] yv, input logic [7:0] th);
    return (xv > th) || (yv > th);
  endfunction
  task results;
    $display("checked %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // The whole run needs roughly 9200 cycles; a hang is cut at about four times that.
  always @(posedge i_clock) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  initial begin
    void'($urandom(89));
    repeat (2) @(negedge i_clock);
    i_rstn = 1'b1;
    repeat (4) @(negedge i_clock);
    chk({o_osc_enable, o_tap_enable, o_nav_enable, o_acq_enable, o_irq, 3'h0}, 8'h00);
    chk({1'b0, o_pointer_config}, 8'h40);
    chk({1'b0, o_tap_config}, 8'h1d);
    rd(4'h1, 1);
    chk(r[7:0], 8'h04);
    rd(4'h2, 1);
    chk(r[7:0], 8'h00);
    $display("reset test done");
    // The host may not read status with the oscillator down: it reads zero.
    wr(4'h2, 8'h04);
    ev(5'b00100, 8'h00, 8'h00);
    chk({7'h0, o_irq}, 8'h01);
    rd(4'h0, 1);
    chk(r[7:0], 8'h00);
    chk({7'h0, o_irq}, 8'h01);
    wr(4'h1, 8'h00);
    ev(5'b00011, 8'h00, 8'h00);
    rd(4'h0, 1);
    chk(r[7:0], 8'h08);
    chk({7'h0, o_irq}, 8'h00);
    rd(4'h0, 1);
    chk(r[7:0], 8'h00);
    wr(4'h1, 8'h08);
    ev(5'b00011, 8'h00, 8'h00);
    rd(4'h0, 1);
    chk(r[7:0], 8'h30);
    $display("status test done");
    foreach (codes[k]) begin
      wr(4'h1, 8'h00);
      wr(4'h1, {1'b0, codes[k], 3'h0});
      m = {4'h0, fix(codes[k])};
      rd(4'h1, 1);
      chk(r[7:0], {1'b0, m[3:0], 3'h0});
      chk({o_acq_enable, o_nav_enable, o_tap_enable, o_test_enable}, m[3:0]);
      chk({7'h0, o_osc_enable}, {7'h0, ~m[3]});
    end
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h14);
    chk({6'h0, o_tap_enable, o_osc_enable}, 8'h00);
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h04);
    chk({7'h0, o_osc_enable}, 8'h00);
    $display("mode test done");
    for (int a = 3; a <= 6; a++) begin
      cfg[a] = 8'($urandom()) & 8'h7f;
      wr(4'(a), cfg[a]);
      rd(4'(a), 1);
      chk(r[7:0], cfg[a]);
    end
    chk({1'b0, o_heater_config}, cfg[3]);
    chk({1'b0, o_pointer_config}, cfg[4]);
    chk({1'b0, o_tap_config}, cfg[5]);
    wr(4'h7, 8'h55);
    rd(4'h7, 1);
    chk(r[7:0], 8'h00);
    rd(4'hb, 1);
    chk(r[7:0], 8'h00);
    $display("register test done");
    t = cfg[6];
    wr(4'h1, 8'h30);
    wr(4'h2, 8'h60);
    for (int k = 0; k < 5; k++) begin
      x = (k == 0) ? t : (k == 1) ? 8'h00 : 8'($urandom());
      y = (k == 0) ? t : (k == 1) ? t + 8'h01 : 8'($urandom());
      ev(5'b01000, x, y);
      chk({7'h0, o_irq}, {7'h0, mot(x, y, t)});
      rd(4'h0, 1);
      chk(r[7:0], {1'b0, mot(x, y, t), 6'h0});
    end
    ev(5'b10000, x, y);
    rd(4'h0, 1);
    chk(r[7:0], 8'h80);
    @(negedge i_clock);
    g = 8'($urandom());
    i_nav_general = g;
    rd(4'h8, 3);
    chk(r[23:16], g);
    chk(r[15:8], x);
    chk(r[7:0], y);
    $display("event test done");
    wr(4'h1, 8'h00);
    wr(4'h1, 8'h40);
    chk({7'h0, o_osc_enable}, {7'h0, cfg[3][5]});
    @(negedge i_clock);
    i_slice_byte = 8'($urandom());
    i_slice_valid = 1'b1;
    i_fast_ss_n = 1'b0;
    for (int k = 0; k < 20; k++) begin
      @(posedge i_clock);
      if (o_slice_ready === 1'b1) break;
    end
    @(negedge i_clock);
    i_slice_valid = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      repeat (4) @(negedge i_clock);
      i_fast_sck = 1'b1;
      repeat (4) @(negedge i_clock);
      i_fast_sck = 1'b0;
      repeat (6) @(negedge i_clock);
      m[i] = o_fast_miso_oe ? o_fast_miso : ~m[(i + 1) % 8];
    end
    chk(m, i_slice_byte);
    i_fast_ss_n = 1'b1;
    $display("slice test done");
    results();
  end
endmodule
`default_nettype wire
